// File: rtl/sysmap_pkg.sv
// constants and field layout for the startup configuration and map block
// assumes a single bus clock; shared by the register bank and its delay timer
package sysmap_pkg;

   // ==========================================================
   // register indices (byte address is four times the index)
   localparam logic [13:0] IDX_OPTIONS     = 14'h1039; // system setup options
   localparam logic [13:0] IDX_PLACEMENT   = 14'h103D; // ram and register placement
   localparam logic [13:0] IDX_STARTUP_OPT = 14'h103F; // startup option latches

   // ==========================================================
   // startup option latch fields
   localparam int CFG_EEPROM_PAGE_LSB = 4; // eeprom_page_sel[3:0]
   localparam int CFG_SECURITY_OFF    = 3;
   localparam int CFG_WATCHDOG_OFF    = 2;
   localparam int CFG_ROM_MAP_ON      = 1;
   localparam int CFG_EEPROM_MAP_ON   = 0;

   // ==========================================================
   // placement fields
   localparam int PLC_RAM_PAGE_LSB = 4; // top hex digit of ram base
   localparam int PLC_REG_PAGE_LSB = 0; // top hex digit of register block base
   localparam logic [7:0] PLC_RESET = 8'h01; // ram on page 0, registers on page 1

   // ==========================================================
   // options fields
   localparam int OPT_ADC_POWER    = 7;
   localparam int OPT_ALT_PUMP_CLK = 6;
   localparam int OPT_IRQ_EDGE     = 5;
   localparam int OPT_WAKE_DELAY   = 4;
   localparam int OPT_CLK_MONITOR  = 3;
   localparam int OPT_RATE_LSB     = 0;
   localparam logic [7:0] OPT_RESET      = 8'h10; // wake delay on, others off
   localparam logic [7:0] OPT_FREE_MASK  = 8'hC8; // writable at any time
   localparam logic [7:0] OPT_ONCE_MASK  = 8'h33; // write-once in early window
   localparam logic [7:0] OPT_IMPL_MASK  = 8'hFB; // bit 2 reads zero

   // ==========================================================
   // timing counts in bus cycles
   localparam logic [6:0]  EARLY_WINDOW_CYC = 7'h40;     // protected write window
   localparam logic [11:0] WAKE_SHORT_CYC   = 12'h004;   // no oscillator delay
   localparam logic [11:0] WAKE_LONG_CYC    = 12'hFA0;   // 4000 cycles
   localparam int          WDOG_DIV_LOG2    = 15;        // bus clock / 2^15

endpackage

// File: rtl/wake_delay_timer.sv
// down counter that reports the end of a programmable delay
// assumes the start pulse and count come from logic on the same clock
`timescale 1ns/1ns
module wake_delay_timer
   import sysmap_pkg::*;
#(
   parameter int WIDTH = 12 // counter width
)
(
   input  wire logic             i_clock,   // bus clock
   input  wire logic             i_reset_n, // synchronous reset, active low
   input  wire logic             i_start,   // one-cycle start pulse
   input  wire logic [WIDTH-1:0] i_count,   // cycles to wait
   output logic                  o_busy,    // delay running
   output logic                  o_done     // one-cycle end pulse
);

   // ==========================================================
   // elaboration check
   if (WIDTH < 3)
   begin : g_width_check
      $error("wake_delay_timer needs WIDTH of at least 3");
   end

   // ==========================================================
   // state
   typedef struct packed {
      logic [WIDTH-1:0] cnt;  // remaining cycles
      logic             busy; // counting
      logic             done; // end pulse
   } tmr_t;

   tmr_t t_reg;  // registered state
   tmr_t t_next; // next state

   // next-state logic
   always_comb
   begin
      t_next      = t_reg;
      t_next.done = 1'b0;
      if (i_start)
      begin
         // restart always wins
         t_next.cnt  = i_count;
         t_next.busy = 1'b1;
      end
      else if (t_reg.busy)
      begin
         if (t_reg.cnt <= WIDTH'(1))
         begin
            t_next.busy = 1'b0;
            t_next.done = 1'b1;
            t_next.cnt  = '0;
         end
         else
         begin
            t_next.cnt = t_reg.cnt - WIDTH'(1);
         end
      end
   end

   // state register
   always_ff @(posedge i_clock)
   begin
      if (!i_reset_n)
         t_reg <= '0;
      else
         t_reg <= t_next;
   end

   assign o_busy = t_reg.busy;
   assign o_done = t_reg.done;

endmodule

// File: rtl/system_config_map_registers.sv
// startup configuration latches, map placement and setup options register bank
// assumes an avalon-mm master on I_CLOCK, nonvolatile byte and mode pins from outside
//
// What this block does
// - copy nonvolatile byte into latches every reset
// - reprogramming byte changes nothing until next reset
// - reads give latches, writes program nonvolatile byte
// - eeprom page picks upper half of page
// - security-off reads one without security option
// - watchdog-off latch one disables the watchdog
// - rom-map zero sends rom range external
// - single-chip mode keeps rom always mapped
// - eeprom-map zero sends eeprom range external
// - placement register writable once in 64 cycles
// - ram page field gives ram base, resets zero
// - register page gives block base, resets one
// - protected option bits write-once early, special anytime
// - no wake delay counts four cycles, resume about nine after stop exit
// - wake delay on waits about 4000 cycles
// - clock select switches pump and converter clock
// - option bits 7:6 and 3 always writable
// - watchdog tick is clock over 2^15 scaled
// - special mode flag lifts write-once protection
`timescale 1ns/1ns
module system_config_map_registers
   import sysmap_pkg::*;
#(
   parameter bit SECURITY_OPTION = 1'b0,          // security option fitted
   parameter int WDOG_LOG2       = WDOG_DIV_LOG2  // watchdog prescale, shorten in sim
)
(
   input  wire logic        I_CLOCK,          // bus clock, 10 MHz
   input  wire logic        I_RESET_N,        // synchronous reset, active low
   input  wire logic [15:0] I_ADDRESS,        // avalon byte address
   input  wire logic        I_READ,           // avalon read
   input  wire logic        I_WRITE,          // avalon write
   input  wire logic [3:0]  I_BYTEENABLE,     // avalon byte enables
   input  wire logic [31:0] I_WRITEDATA,      // avalon write data
   output logic [31:0]      O_READDATA,       // avalon read data
   output logic             O_WAITREQUEST,    // avalon wait request
   input  wire logic [7:0]  I_NV_OPTION_BYTE, // nonvolatile option byte
   input  wire logic        I_MODE_B,         // mode pin b
   input  wire logic        I_MODE_A,         // mode pin a
   input  wire logic        I_STOP_EXIT,      // leave stop mode request
   output logic [7:0]       O_NV_PROG_DATA,   // byte to program
   output logic             O_NV_PROG_STROBE, // program pulse
   output logic [3:0]       O_EEPROM_PAGE,    // eeprom page sel
   output logic             O_SECURITY_ON,    // security active
   output logic             O_WATCHDOG_EN,    // watchdog running
   output logic             O_WATCHDOG_TICK,  // watchdog clock pulse
   output logic             O_ROM_IN_MAP,     // rom decoded internally
   output logic             O_EEPROM_IN_MAP,  // eeprom decoded internally
   output logic [3:0]       O_RAM_PAGE,       // ram base top digit
   output logic [3:0]       O_REG_PAGE,       // register block top digit
   output logic             O_INTERRUPT_EDGE_ONLY, // edge-only interrupt
   output logic             O_ALT_PUMP_CLOCK, // alternate pump and adc clock
   output logic             O_ADC_POWER,      // converter power
   output logic             O_CLOCK_MONITOR,  // clock monitor enable
   output logic             O_SPECIAL_MODE,   // special mode flag
   output logic             O_RESUME          // one-cycle resume after stop
);

   // ==========================================================
   // elaboration check
   // a prescaler past 24 bits only slows simulation
   if (WDOG_LOG2 < 1 || WDOG_LOG2 > 24)
   begin : g_wdog_check
      $error("WDOG_LOG2 must lie in 1..24");
   end

   localparam int WDW = WDOG_LOG2 + 6; // prescaler plus rate bits

   // ==========================================================
   // state
   typedef struct packed {
      logic [7:0]     nv_s1;     // option byte sync stage 1
      logic [7:0]     nv_s2;     // option byte sync stage 2
      logic [1:0]     mod_s1;    // mode pins stage 1
      logic [1:0]     mod_s2;    // mode pins stage 2
      logic           stop_s1;   // stop exit stage 1
      logic           stop_s2;   // stop exit stage 2
      logic           stop_d;    // stop exit edge memory
      logic [7:0]     cfg;       // working option latches
      logic           special;   // special mode flag
      logic           single;    // single-chip mode
      logic [7:0]     plc;       // placement register
      logic           plc_used;  // placement write taken
      logic [7:0]     opt;       // options register
      logic           opt_used;  // protected options write taken
      logic [6:0]     win;       // cycles since reset release
      logic           ack;       // bus answer cycle
      logic [7:0]     rdata;     // read data
      logic [7:0]     prog_data; // byte to program
      logic           prog_stb;  // program pulse
      logic [WDW-1:0] wdt;       // watchdog prescaler
      logic           wdt_tick;  // watchdog tick
      logic           wake_go;   // start wake timer
      logic           resume;    // resume pulse
      logic           rom_in;    // rom mapped
      logic           ee_in;     // eeprom mapped
      logic           sec_on;    // security active
      logic           wd_en;     // watchdog enabled
   } regs_t;

   regs_t st_reg;  // registered state
   regs_t st_next; // next state

   logic        wake_done;  // wake delay elapsed
   logic [11:0] wake_count; // selected delay

   // ==========================================================
   // wake delay after stop
   assign wake_count = st_reg.opt[OPT_WAKE_DELAY] ? WAKE_LONG_CYC
                                                  : WAKE_SHORT_CYC;

   wake_delay_timer #(
      .WIDTH (12)
   ) u_wake (
      .i_clock   (I_CLOCK),
      .i_reset_n (I_RESET_N),
      .i_start   (st_reg.wake_go),
      .i_count   (wake_count),
      .o_busy    (),
      .o_done    (wake_done)
   );

   // ==========================================================
   // next-state logic
   always_comb
   begin
      logic [13:0] idx;      // word index
      logic        hit;      // aligned access
      logic        wr_take;  // write commits now
      logic        window;   // early window open
      logic        lanes;    // low lane enabled
      logic [7:0]  wd;       // write byte
      logic [7:0]  rd;       // read byte
      logic [4:0]  rsh;      // watchdog tap
      idx     = I_ADDRESS[15:2];
      hit     = (I_ADDRESS[1:0] == 2'b00);
      wd      = I_WRITEDATA[7:0];
      lanes   = I_BYTEENABLE[0];
      window  = (st_reg.win < EARLY_WINDOW_CYC);
      wr_take = 1'b0;  // set once the bus answers
      rd      = 8'h00; // unmapped default
      rsh     = 5'h00; // set from the rate field
      st_next = st_reg;

      // input synchronisers
      // stop exit keeps a third stage for edge detection
      st_next.nv_s1   = I_NV_OPTION_BYTE;
      st_next.nv_s2   = st_reg.nv_s1;
      st_next.mod_s1  = {I_MODE_B, I_MODE_A};
      st_next.mod_s2  = st_reg.mod_s1;
      st_next.stop_s1 = I_STOP_EXIT;
      st_next.stop_s2 = st_reg.stop_s1;
      st_next.stop_d  = st_reg.stop_s2;

      // early window counter, saturates
      // hazard: the window is tested on the commit cycle
      if (window)
         st_next.win = st_reg.win + 7'h01;

      // bus answer: one wait cycle, then one ready cycle
      // a write lands on the edge where waitrequest is low
      st_next.ack      = (I_READ || I_WRITE) && !st_reg.ack;
      wr_take          = I_WRITE && st_reg.ack && hit && lanes;
      st_next.prog_stb = 1'b0;

      // read mux, latched for the answer cycle
      // misaligned or unmapped addresses read zero
      rd = 8'h00;
      if (hit)
      begin
         unique case (idx)
            IDX_STARTUP_OPT:
            begin
               rd = st_reg.cfg;
               if (!SECURITY_OPTION)
                  rd[CFG_SECURITY_OFF] = 1'b1;
            end
            IDX_PLACEMENT: rd = st_reg.plc;
            IDX_OPTIONS:   rd = st_reg.opt & OPT_IMPL_MASK;
            default:       rd = 8'h00; // unmapped reads zero
         endcase
      end
      if (I_READ && !st_reg.ack)
         st_next.rdata = rd;

      // register writes
      if (wr_take)
      begin
         unique case (idx)
            IDX_STARTUP_OPT:
            begin
               // only the nonvolatile byte is programmed
               st_next.prog_data = wd;
               st_next.prog_stb  = 1'b1;
            end
            IDX_PLACEMENT:
            begin
               // special mode: any number of writes
               if (st_reg.special)
                  st_next.plc = wd;
               // normal mode: one write in the window
               else if (window && !st_reg.plc_used)
               begin
                  st_next.plc      = wd;
                  st_next.plc_used = 1'b1;
               end
            end
            IDX_OPTIONS:
            begin
               // free bits always land
               st_next.opt = (st_reg.opt & ~OPT_FREE_MASK)
                           | (wd & OPT_FREE_MASK);
               // special mode: protected bits always open
               if (st_reg.special)
                  st_next.opt = wd & OPT_IMPL_MASK;
               else if (window && !st_reg.opt_used)
               begin
                  st_next.opt = (st_next.opt & ~OPT_ONCE_MASK)
                              | (wd & OPT_ONCE_MASK);
                  st_next.opt_used = 1'b1;
               end
            end
            default: ; // unmapped writes ignored
         endcase
      end

      // map and system controls from the working latches
      st_next.rom_in = st_reg.cfg[CFG_ROM_MAP_ON] || st_reg.single;
      st_next.ee_in  = st_reg.cfg[CFG_EEPROM_MAP_ON];
      st_next.sec_on = SECURITY_OPTION && !st_reg.cfg[CFG_SECURITY_OFF];
      st_next.wd_en  = !st_reg.cfg[CFG_WATCHDOG_OFF];

      // watchdog clock: 2^WDOG_LOG2 times 4^rate
      // prescaler held at zero while the watchdog is off
      rsh = 5'(2 * st_reg.opt[OPT_RATE_LSB +: 2]);
      st_next.wdt      = st_reg.wd_en ? st_reg.wdt + WDW'(1) : '0;
      st_next.wdt_tick = st_reg.wd_en
                      && ((st_reg.wdt >> rsh) & WDW'((1 << WDOG_LOG2) - 1))
                         == WDW'((1 << WDOG_LOG2) - 1)
                      && (st_reg.wdt & ((WDW'(1) << rsh) - WDW'(1)))
                         == ((WDW'(1) << rsh) - WDW'(1));

      // stop exit edge starts the wake delay
      st_next.wake_go = st_reg.stop_s2 && !st_reg.stop_d;
      // resume follows the timer end pulse by one cycle
      st_next.resume  = wake_done;
   end

   // ==========================================================
   // state register; reset reloads latches and straps
   // option byte and mode pin synchronisers keep shifting in reset so latches settle
   // limitation: option byte must hold for three reset edges
   always_ff @(posedge I_CLOCK)
   begin
      if (!I_RESET_N)
      begin
         st_reg          <= '0;
         st_reg.nv_s1    <= I_NV_OPTION_BYTE;
         st_reg.nv_s2    <= st_reg.nv_s1;
         st_reg.mod_s1   <= {I_MODE_B, I_MODE_A};
         st_reg.mod_s2   <= st_reg.mod_s1;
         st_reg.cfg      <= st_reg.nv_s2;
         st_reg.special  <= !st_reg.mod_s2[1];
         st_reg.single   <= st_reg.mod_s2 == 2'b10;
         st_reg.plc      <= PLC_RESET;
         st_reg.opt      <= OPT_RESET;
         // map controls stay safe until latches drive them
         st_reg.rom_in   <= 1'b1;
         st_reg.ee_in    <= 1'b0;
         st_reg.sec_on   <= 1'b0;
         st_reg.wd_en    <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // outputs, all straight from flip-flops
   // upper read data lanes are always zero
   assign O_READDATA            = {24'h000000, st_reg.rdata};
   assign O_WAITREQUEST         = !st_reg.ack;
   assign O_NV_PROG_DATA        = st_reg.prog_data;
   assign O_NV_PROG_STROBE      = st_reg.prog_stb;
   assign O_EEPROM_PAGE         = st_reg.cfg[CFG_EEPROM_PAGE_LSB +: 4];
   assign O_SECURITY_ON         = st_reg.sec_on;
   assign O_WATCHDOG_EN         = st_reg.wd_en;
   assign O_WATCHDOG_TICK       = st_reg.wdt_tick;
   assign O_ROM_IN_MAP          = st_reg.rom_in;
   assign O_EEPROM_IN_MAP       = st_reg.ee_in;
   assign O_RAM_PAGE            = st_reg.plc[PLC_RAM_PAGE_LSB +: 4];
   assign O_REG_PAGE            = st_reg.plc[PLC_REG_PAGE_LSB +: 4];
   assign O_INTERRUPT_EDGE_ONLY = st_reg.opt[OPT_IRQ_EDGE];
   assign O_ALT_PUMP_CLOCK      = st_reg.opt[OPT_ALT_PUMP_CLK];
   assign O_ADC_POWER           = st_reg.opt[OPT_ADC_POWER];
   assign O_CLOCK_MONITOR       = st_reg.opt[OPT_CLK_MONITOR];
   assign O_SPECIAL_MODE        = st_reg.special;
   assign O_RESUME              = st_reg.resume;

endmodule

// File: tb/system_config_map_registers_sva.sv
// checker for the startup configuration and map register bank
// assumes it is bound onto the top module; one bus clock, synchronous reset
`timescale 1ns/1ns
module system_config_map_registers_sva
#(
   parameter bit SECURITY_OPTION = 1'b0 // security option fitted
)
(
   input wire logic        I_CLOCK,
   input wire logic        I_RESET_N,
   input wire logic [15:0] I_ADDRESS,
   input wire logic        I_READ,
   input wire logic        I_WRITE,
   input wire logic [31:0] I_WRITEDATA,
   input wire logic        I_STOP_EXIT,
   input wire logic [31:0] O_READDATA,
   input wire logic        O_WAITREQUEST,
   input wire logic [7:0]  O_NV_PROG_DATA,
   input wire logic        O_NV_PROG_STROBE,
   input wire logic [3:0]  O_EEPROM_PAGE,
   input wire logic        O_SECURITY_ON,
   input wire logic        O_WATCHDOG_EN,
   input wire logic        O_WATCHDOG_TICK,
   input wire logic        O_ROM_IN_MAP,
   input wire logic        O_EEPROM_IN_MAP,
   input wire logic        O_RESUME
);
   // ==========================================================
   // clocking and bus handshake steps
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (!I_RESET_N);
   // request seen while slave still waiting
   sequence s_taken;
      (I_READ || I_WRITE) && O_WAITREQUEST;
   endsequence
   // exactly one ready cycle
   sequence s_ack;
      !O_WAITREQUEST ##1 O_WAITREQUEST;
   endsequence

   // ==========================================================
   // helper: cycles spent waiting for resume after a stop exit edge
   logic        stop_seen; // stop exit one cycle back
   logic        waiting;   // resume outstanding
   logic [12:0] wait_cnt;  // cycles since the edge
   always_ff @(posedge I_CLOCK)
   begin
      stop_seen <= I_STOP_EXIT;
      if (!I_RESET_N || O_RESUME)
      begin
         waiting  <= 1'b0;
         wait_cnt <= 13'h0000;
      end
      else if (I_STOP_EXIT && !stop_seen)
         waiting <= 1'b1;
      else if (waiting)
         wait_cnt <= wait_cnt + 13'h0001;
   end

   // ==========================================================
   // assertions
   a_req_answered: assert property (s_taken |=> s_ack)
      else $error("bus request not answered after one wait cycle");
   a_ready_has_cause: assert property ($fell(O_WAITREQUEST)
      |-> $past(I_READ) || $past(I_WRITE))
      else $error("ready without a request");
   a_readdata_upper: assert property (!O_WAITREQUEST
      |-> O_READDATA[31:8] == 24'h000000)
      else $error("upper read data not zero");
   a_prog_source: assert property (O_NV_PROG_STROBE |-> $past(I_WRITE)
      && $past(I_ADDRESS) == 16'h40FC
      && {24'h000000, O_NV_PROG_DATA} == $past(I_WRITEDATA))
      else $error("program strobe without matching write");
   a_strobe_single: assert property (O_NV_PROG_STROBE |=> !O_NV_PROG_STROBE)
      else $error("program strobe longer than one cycle");
   a_map_held: assert property ($past(I_RESET_N, 3) |-> $stable(O_EEPROM_PAGE)
      && $stable(O_WATCHDOG_EN) && $stable(O_ROM_IN_MAP) && $stable(O_EEPROM_IN_MAP))
      else $error("map outputs changed without reset");
   a_watchdog_quiet: assert property (!O_WATCHDOG_EN |-> !O_WATCHDOG_TICK)
      else $error("watchdog tick while disabled");
   a_security_absent: assert property (!SECURITY_OPTION |-> !O_SECURITY_ON)
      else $error("security on without option");
   a_resume_bounded: assert property (waiting |-> wait_cnt <= 13'h0FC8)
      else $error("no resume after stop exit");
endmodule

// File: tb/system_config_map_registers_tb.sv
// self-checking bench for the startup configuration and map register bank
// assumes the design answers each bus request after one wait cycle
`timescale 1ns/1ns
module system_config_map_registers_tb
   import sysmap_pkg::*;
;
   localparam int WLOG = 4; // shortened watchdog prescale
   localparam logic [15:0] A_OPT = {IDX_OPTIONS, 2'b00};     // options byte address
   localparam logic [15:0] A_PLC = {IDX_PLACEMENT, 2'b00};   // placement byte address
   localparam logic [15:0] A_CFG = {IDX_STARTUP_OPT, 2'b00}; // startup latches address
   logic I_CLOCK, I_RESET_N, I_READ, I_WRITE, I_MODE_B, I_MODE_A, I_STOP_EXIT;
   logic [15:0] I_ADDRESS;
   logic [3:0]  I_BYTEENABLE, O_EEPROM_PAGE, O_RAM_PAGE, O_REG_PAGE;
   logic [31:0] I_WRITEDATA, O_READDATA;
   logic [7:0]  I_NV_OPTION_BYTE, O_NV_PROG_DATA, q;
   logic O_WAITREQUEST, O_NV_PROG_STROBE, O_SECURITY_ON, O_WATCHDOG_EN, O_WATCHDOG_TICK;
   logic O_ROM_IN_MAP, O_EEPROM_IN_MAP, O_INTERRUPT_EDGE_ONLY, O_ALT_PUMP_CLOCK;
   logic O_ADC_POWER, O_CLOCK_MONITOR, O_SPECIAL_MODE, O_RESUME;
   int err_total = 0; // mismatches
   int tests_run = 0; // comparisons

   system_config_map_registers #(.SECURITY_OPTION(1'b0), .WDOG_LOG2(WLOG)) dut (
      .I_CLOCK(I_CLOCK), .I_RESET_N(I_RESET_N), .I_ADDRESS(I_ADDRESS), .I_READ(I_READ),
      .I_WRITE(I_WRITE), .I_BYTEENABLE(I_BYTEENABLE), .I_WRITEDATA(I_WRITEDATA),
      .O_READDATA(O_READDATA), .O_WAITREQUEST(O_WAITREQUEST),
      .I_NV_OPTION_BYTE(I_NV_OPTION_BYTE), .I_MODE_B(I_MODE_B), .I_MODE_A(I_MODE_A),
      .I_STOP_EXIT(I_STOP_EXIT), .O_NV_PROG_DATA(O_NV_PROG_DATA),
      .O_NV_PROG_STROBE(O_NV_PROG_STROBE), .O_EEPROM_PAGE(O_EEPROM_PAGE),
      .O_SECURITY_ON(O_SECURITY_ON), .O_WATCHDOG_EN(O_WATCHDOG_EN),
      .O_WATCHDOG_TICK(O_WATCHDOG_TICK), .O_ROM_IN_MAP(O_ROM_IN_MAP),
      .O_EEPROM_IN_MAP(O_EEPROM_IN_MAP), .O_RAM_PAGE(O_RAM_PAGE), .O_REG_PAGE(O_REG_PAGE),
      .O_INTERRUPT_EDGE_ONLY(O_INTERRUPT_EDGE_ONLY), .O_ALT_PUMP_CLOCK(O_ALT_PUMP_CLOCK),
      .O_ADC_POWER(O_ADC_POWER), .O_CLOCK_MONITOR(O_CLOCK_MONITOR),
      .O_SPECIAL_MODE(O_SPECIAL_MODE), .O_RESUME(O_RESUME));

   // ==========================================================
   // shared tasks
   // one comparison, counted
   task check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge I_CLOCK);
   endtask
   // one avalon transfer, held until ready is sampled low
   task bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
      I_ADDRESS <= a;
      I_WRITEDATA <= {24'h000000, d};
      I_WRITE <= wr;
      I_READ <= !wr;
      do
         @(posedge I_CLOCK);
      while (O_WAITREQUEST !== 1'b0);
      q = O_READDATA[7:0];
      I_READ <= 1'b0;
      I_WRITE <= 1'b0;
      @(posedge I_CLOCK);
   endtask
   task wr(input logic [15:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask
   task rd_chk(input logic [15:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      check(q, exp);
   endtask
   // reset with given stored byte and mode pins
   task rst(input logic [7:0] nv, input logic mb, input logic ma);
      I_RESET_N <= 1'b0;
      I_NV_OPTION_BYTE <= nv;
      I_MODE_B <= mb;
      I_MODE_A <= ma;
      cyc(6);
      I_RESET_N <= 1'b1;
      cyc(3);
   endtask
   // cycles between two watchdog ticks
   task tick_period(input int exp);
      int n;
      n = 0;
      while (O_WATCHDOG_TICK !== 1'b1 && n < 3000)
      begin
         @(posedge I_CLOCK);
         n++;
      end
      n = 0;
      do
      begin
         @(posedge I_CLOCK);
         n++;
      end
      while (O_WATCHDOG_TICK !== 1'b1 && n < 3000);
      check(n, exp);
   endtask
   // cycles from stop exit to resume pulse, within bounds
   task wake(input int lo, input int hi);
      int n;
      I_STOP_EXIT <= 1'b1;
      n = 0;
      do
      begin
         @(posedge I_CLOCK);
         n++;
      end
      while (O_RESUME !== 1'b1 && n <= hi);
      I_STOP_EXIT <= 1'b0;
      check({31'h0, n >= lo && n <= hi}, 32'h1);
   endtask

   // ==========================================================
   // scenarios
   // expanded mode start, then reprogram without reset
   task t_startup;
      check(O_EEPROM_PAGE, 4'hA);
      check(O_WATCHDOG_EN, 1'b0);
      check(O_ROM_IN_MAP, 1'b0);
      check(O_EEPROM_IN_MAP, 1'b1);
      check(O_SECURITY_ON, 1'b0);
      rd_chk(A_CFG, 8'hAD);
      rd_chk(A_PLC, PLC_RESET);
      check(O_RAM_PAGE, 4'h0);
      check(O_REG_PAGE, 4'h1);
      rd_chk(A_OPT, OPT_RESET);
      wr(A_CFG, 8'h3C);
      check(O_NV_PROG_DATA, 8'h3C);
      I_NV_OPTION_BYTE <= 8'h50;
      cyc(8);
      check(O_EEPROM_PAGE, 4'hA);
      rd_chk(A_CFG, 8'hAD);
   endtask
   // single chip: one write each in the early window
   task t_window;
      rst(8'h50, 1'b1, 1'b0);
      check(O_ROM_IN_MAP, 1'b1);
      check(O_EEPROM_PAGE, 4'h5);
      check(O_WATCHDOG_EN, 1'b1);
      wr(A_PLC, 8'h23);
      wr(A_PLC, 8'h45);
      rd_chk(A_PLC, 8'h23);
      check(O_RAM_PAGE, 4'h2);
      check(O_REG_PAGE, 4'h3);
      wr(A_OPT, 8'hF3);
      check(O_ALT_PUMP_CLOCK, 1'b1);
      check(O_INTERRUPT_EDGE_ONLY, 1'b1);
      wr(A_OPT, 8'h08);
      rd_chk(A_OPT, 8'h3B);
      check(O_CLOCK_MONITOR, 1'b1);
      check(O_ADC_POWER, 1'b0);
      tick_period(1 << (WLOG + 6));
      wake(3995, 4030);
   endtask
   // normal mode writes after the window closed
   task t_late;
      rst(8'hA5, 1'b1, 1'b1);
      cyc(70);
      wr(A_PLC, 8'h77);
      rd_chk(A_PLC, PLC_RESET);
      wr(A_OPT, 8'hC3);
      rd_chk(A_OPT, 8'hD0);
   endtask
   // special test mode: late and repeated writes accepted
   task t_special;
      rst(8'h50, 1'b0, 1'b1);
      check(O_SPECIAL_MODE, 1'b1);
      check(O_ROM_IN_MAP, 1'b0);
      cyc(70);
      wr(A_OPT, 8'h00);
      rd_chk(A_OPT, 8'h00);
      wr(A_PLC, 8'h9E);
      wr(A_PLC, 8'h6B);
      rd_chk(A_PLC, 8'h6B);
      wake(2, 16);
      rd_chk(16'h40E6, 8'h00);
      wr(16'h4100, 8'h5A);
      rd_chk(16'h4100, 8'h00);
   endtask

   // ==========================================================
   // verdict, clock, hang guard and main sequence
   task final_report;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      I_CLOCK = 1'b0;
      forever #50 I_CLOCK = ~I_CLOCK;
   end
   initial
   begin
      cyc(20000);
      err_total++;
      final_report();
   end
   initial
   begin
      {I_RESET_N, I_READ, I_WRITE, I_STOP_EXIT, I_ADDRESS, I_WRITEDATA} = '0;
      {I_MODE_B, I_MODE_A, I_BYTEENABLE, I_NV_OPTION_BYTE} = {2'b11, 4'hF, 8'hA5};
      cyc(4);
      I_RESET_N <= 1'b1;
      cyc(3);
      t_startup();
      t_window();
      t_late();
      t_special();
      final_report();
   end
endmodule

bind system_config_map_registers system_config_map_registers_sva
   #(.SECURITY_OPTION(SECURITY_OPTION)) u_sva (
   .I_CLOCK(I_CLOCK), .I_RESET_N(I_RESET_N), .I_ADDRESS(I_ADDRESS), .I_READ(I_READ),
   .I_WRITE(I_WRITE), .I_WRITEDATA(I_WRITEDATA), .I_STOP_EXIT(I_STOP_EXIT),
   .O_READDATA(O_READDATA), .O_WAITREQUEST(O_WAITREQUEST), .O_NV_PROG_DATA(O_NV_PROG_DATA),
   .O_NV_PROG_STROBE(O_NV_PROG_STROBE), .O_EEPROM_PAGE(O_EEPROM_PAGE),
   .O_SECURITY_ON(O_SECURITY_ON), .O_WATCHDOG_EN(O_WATCHDOG_EN),
   .O_WATCHDOG_TICK(O_WATCHDOG_TICK), .O_ROM_IN_MAP(O_ROM_IN_MAP),
   .O_EEPROM_IN_MAP(O_EEPROM_IN_MAP), .O_RESUME(O_RESUME));
